/* hdl/pgm_pkg.sv */
// Package: register map, field layout, reset values and DAC scaling constants
`default_nettype none
package pgm_pkg;
  // ==========================================================
  // Register indices and byte addresses
  localparam logic [7:0]  IDX_CUR_GAIN   = 8'hf0;
  localparam logic [7:0]  IDX_SPD_GAIN   = 8'hf2;
  localparam logic [7:0]  IDX_MON1_CTRL  = 8'hf4;
  localparam logic [11:0] ADDR_CUR_GAIN  = {2'h0, IDX_CUR_GAIN, 2'h0};
  localparam logic [11:0] ADDR_SPD_GAIN  = {2'h0, IDX_SPD_GAIN, 2'h0};
  localparam logic [11:0] ADDR_MON1_CTRL = {2'h0, IDX_MON1_CTRL, 2'h0};
  localparam int          ADDR_W         = 12;
  // ==========================================================
  // Field layout
  localparam int GAIN_W      = 10;
  localparam int HI_LSB      = 16;
  localparam int PTR_LSB     = 0;
  localparam int PTR_W       = 12;
  localparam int POL_BIT     = 12;
  localparam int FRAC_LSB    = 13;
  localparam int SCL_W       = 4;
  localparam int SHIFT_LSB   = 17;
  localparam int CTRL_USED_W = 21;
  // ==========================================================
  // Reset values
  localparam logic [31:0] MON1_CTRL_RST = 32'h0011_0000;
  localparam logic [3:0]  FRAC_RST      = 4'h8;
  localparam logic [3:0]  SHIFT_RST     = 4'h8;
  localparam logic        POL_RST       = 1'h0;
  // ==========================================================
  // DAC code mapping
  localparam int          VAR_W      = 16;
  localparam int          DAC_W      = 12;
  localparam int          FRAC_SHIFT = 3;
  localparam logic [4:0]  ENUM_MAX   = 5'h1f;
  localparam logic [11:0] DAC_MID    = 12'h800;
  localparam logic [11:0] DAC_FULL   = 12'hfff;
  // ==========================================================
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  typedef enum logic [1:0] {
    PGM_ST_IDLE  = 2'b00,
    PGM_ST_WRITE = 2'b01,
    PGM_ST_READ  = 2'b10
  } pgm_phase_e;
endpackage : pgm_pkg
`default_nettype wire

/* hdl/pgm_ahb_slave.sv */
// AHB-Lite slave front end: address-phase capture and data-phase strobes
`default_nettype none
module pgm_ahb_slave (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic                   hready,
  output var  logic                   wr_stb,
  output var  logic                   rd_stb,
  output var  logic [pgm_pkg::ADDR_W-1:0] dp_addr
);
  // ==========================================================
  // Address phase
  wire logic xfer_ok;
  assign xfer_ok = hsel && hready && hsize == pgm_pkg::HSIZE_WORD &&
                   (htrans == pgm_pkg::HTRANS_NONSEQ || htrans == pgm_pkg::HTRANS_SEQ);
  pgm_pkg::pgm_phase_e phase_r;
  pgm_pkg::pgm_phase_e phase_nxt;
  logic [pgm_pkg::ADDR_W-1:0] addr_r;
  always_comb begin
    case ({xfer_ok, hwrite})
      2'b11:   phase_nxt = pgm_pkg::PGM_ST_WRITE;
      2'b10:   phase_nxt = pgm_pkg::PGM_ST_READ;
      default: phase_nxt = pgm_pkg::PGM_ST_IDLE;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r <= pgm_pkg::PGM_ST_IDLE;
      addr_r  <= '0;
    end else begin
      phase_r <= phase_nxt;
      if (xfer_ok) addr_r <= haddr[pgm_pkg::ADDR_W-1:0];
    end
  end
  // ==========================================================
  // Data phase; zero wait states
  assign wr_stb  = phase_r == pgm_pkg::PGM_ST_WRITE;
  assign rd_stb  = phase_r == pgm_pkg::PGM_ST_READ;
  assign dp_addr = addr_r;
endmodule : pgm_ahb_slave
`default_nettype wire

/* hdl/pgm_dac_scaler.sv */
// Monitor DAC code generator: fractional or power-of-two scaling, polarity map
`default_nettype none
module pgm_dac_scaler #(
  parameter int VAR_W = pgm_pkg::VAR_W,
  parameter int DAC_W = pgm_pkg::DAC_W
) (
  input  wire logic [VAR_W-1:0] var_value,
  input  wire logic [3:0]       frac_scale,
  input  wire logic [3:0]       power_shift,
  input  wire logic             unipolar,
  output var  logic [DAC_W-1:0] dac_code
);
  // ==========================================================
  // Saturate a signed scaled value to the 1 pu range
  localparam int WIDE = VAR_W + 20;
  function automatic logic signed [WIDE-1:0] sat_pu(input logic signed [WIDE-1:0] v,
                                                    input logic signed [WIDE-1:0] hi,
                                                    input logic signed [WIDE-1:0] lo);
    sat_pu = (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction : sat_pu
  wire logic               enum_mode;
  wire logic signed [WIDE-1:0] sv;
  wire logic signed [WIDE-1:0] frac_prod;
  wire logic        [WIDE-1:0] enum_prod;
  wire logic signed [WIDE-1:0] pu_one;
  wire logic signed [WIDE-1:0] scaled;
  wire logic signed [WIDE-1:0] bip;
  wire logic signed [WIDE-1:0] uni;
  wire logic               [4:0] enum_val;
  assign enum_mode = frac_scale == 4'h0;
  assign sv        = WIDE'(signed'(var_value));
  // 1 pu is full scale of the signed variable
  assign pu_one    = WIDE'(1) <<< (VAR_W - 1);
  assign frac_prod = (sv * signed'(WIDE'(frac_scale))) >>> pgm_pkg::FRAC_SHIFT;
  // Enum values above the documented maximum are clipped rather than wrapped
  assign enum_val  = (var_value > VAR_W'(pgm_pkg::ENUM_MAX)) ? pgm_pkg::ENUM_MAX
                                                             : var_value[4:0];
  assign enum_prod = WIDE'(enum_val) << power_shift;
  assign scaled    = enum_mode ? signed'(enum_prod) : frac_prod;
  // ==========================================================
  // Bipolar: -1 pu to code 0, +1 pu to full scale, 0 pu mid
  assign bip = (sat_pu(scaled, pu_one - 1, -pu_one) + pu_one) >>> (VAR_W - DAC_W);
  // Unipolar: 0 pu to code 0, 1 pu to full scale
  assign uni = sat_pu(scaled, pu_one - 1, '0) >>> (VAR_W - 1 - DAC_W);
  assign dac_code = unipolar ? uni[DAC_W-1:0] : bip[DAC_W-1:0];
endmodule : pgm_dac_scaler
`default_nettype wire

/* hdl/pgm_top.sv */
// PI gain readback and first monitor DAC control register block
`default_nettype none
module pgm_top #(
  parameter int VAR_W = pgm_pkg::VAR_W,
  parameter int DAC_W = pgm_pkg::DAC_W
) (
  input  wire logic                              hclk,
  input  wire logic                              hresetn,
  input  wire logic                              hsel,
  input  wire logic [31:0]                       haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic [31:0]                       hwdata,
  input  wire logic                              hready,
  output var  logic [31:0]                       hrdata,
  output var  logic                              hreadyout,
  output var  logic                              hresp,
  input  wire logic [pgm_pkg::GAIN_W-1:0]        cur_integral_gain_used,
  input  wire logic [pgm_pkg::GAIN_W-1:0]        cur_proportional_gain_used,
  input  wire logic [pgm_pkg::GAIN_W-1:0]        spd_integral_gain_used,
  input  wire logic [pgm_pkg::GAIN_W-1:0]        spd_proportional_gain_used,
  input  wire logic [VAR_W-1:0]                  monitor_variable_value,
  output var  logic [pgm_pkg::PTR_W-1:0]         monitor_one_variable_pointer,
  output var  logic [DAC_W-1:0]                  monitor_output_one
);
  // ==========================================================
  // Bus front end
  wire logic                       wr_stb;
  wire logic                       rd_stb;
  wire logic [pgm_pkg::ADDR_W-1:0] dp_addr;
  pgm_ahb_slave u_slave (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hsel    (hsel),
    .haddr   (haddr),
    .htrans  (htrans),
    .hwrite  (hwrite),
    .hsize   (hsize),
    .hready  (hready),
    .wr_stb  (wr_stb),
    .rd_stb  (rd_stb),
    .dp_addr (dp_addr)
  );

  // ==========================================================
  // Address decode
  wire logic sel_cur;
  wire logic sel_spd;
  wire logic sel_ctl;
  assign sel_cur = dp_addr == pgm_pkg::ADDR_CUR_GAIN;
  assign sel_spd = dp_addr == pgm_pkg::ADDR_SPD_GAIN;
  assign sel_ctl = dp_addr == pgm_pkg::ADDR_MON1_CTRL;

  // ==========================================================
  // Monitor one control fields
  logic [pgm_pkg::PTR_W-1:0] ptr_r;
  logic                      pol_r;
  logic [pgm_pkg::SCL_W-1:0] frac_r;
  logic [pgm_pkg::SCL_W-1:0] shift_r;
  wire logic                 ctl_wr;
  assign ctl_wr = wr_stb && sel_ctl;
  // Only bits 20-0 are stored; upper bits are dropped on write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_r   <= '0;
      pol_r   <= pgm_pkg::POL_RST;
      frac_r  <= pgm_pkg::FRAC_RST;
      shift_r <= pgm_pkg::SHIFT_RST;
    end else if (ctl_wr) begin
      ptr_r   <= hwdata[pgm_pkg::PTR_LSB +: pgm_pkg::PTR_W];
      pol_r   <= hwdata[pgm_pkg::POL_BIT];
      frac_r  <= hwdata[pgm_pkg::FRAC_LSB +: pgm_pkg::SCL_W];
      shift_r <= hwdata[pgm_pkg::SHIFT_LSB +: pgm_pkg::SCL_W];
    end
  end

  wire logic [31:0] ctl_word;
  assign ctl_word = {{(32 - pgm_pkg::CTRL_USED_W){1'b0}}, shift_r, frac_r, pol_r, ptr_r};

  // ==========================================================
  // Read data; gains are zero-extended into each half-word
  wire logic [31:0] cur_word;
  wire logic [31:0] spd_word;
  wire logic [31:0] rd_word;
  assign cur_word = {6'h00, cur_integral_gain_used, 6'h00, cur_proportional_gain_used};
  assign spd_word = {6'h00, spd_integral_gain_used, 6'h00, spd_proportional_gain_used};
  assign rd_word  = sel_cur ? cur_word :
                    sel_spd ? spd_word :
                    sel_ctl ? ctl_word : 32'h0000_0000;
  // Unmapped reads return zero, unmapped writes are dropped; always OKAY
  assign hrdata    = rd_stb ? rd_word : 32'h0000_0000;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ==========================================================
  // Monitor DAC path, registered so the output is glitch free
  wire logic [DAC_W-1:0] dac_nxt;
  logic      [DAC_W-1:0] dac_r;
  pgm_dac_scaler #(.VAR_W(VAR_W), .DAC_W(DAC_W)) u_scaler (
    .var_value   (monitor_variable_value),
    .frac_scale  (frac_r),
    .power_shift (shift_r),
    .unipolar    (pol_r),
    .dac_code    (dac_nxt)
  );
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) dac_r <= '0;
    else          dac_r <= dac_nxt;
  end
  assign monitor_output_one           = dac_r;
  assign monitor_one_variable_pointer = ptr_r;

  // ==========================================================
  // Checks
  sequence s_ctl_write;
    ctl_wr;
  endsequence
  a_ptr_takes_write: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ctl_write |=> monitor_one_variable_pointer == $past(hwdata[11:0]))
    else $error("pointer did not take written value");
  a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_stb && sel_ctl |-> hrdata[31:21] == 11'h000)
    else $error("reserved control bits read nonzero");
  a_cur_ki_read: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_stb && sel_cur |-> hrdata[25:16] == cur_integral_gain_used && hrdata[31:26] == 6'h00)
    else $error("current integral gain readback wrong");
  a_cur_kp_read: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_stb && sel_cur |-> hrdata[15:0] == {6'h00, cur_proportional_gain_used})
    else $error("current proportional gain readback wrong");
  a_spd_ki_read: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_stb && sel_spd |-> hrdata[31:16] == {6'h00, spd_integral_gain_used})
    else $error("speed integral gain readback wrong");
  a_spd_kp_read: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_stb && sel_spd |-> hrdata[15:0] == {6'h00, spd_proportional_gain_used})
    else $error("speed proportional gain readback wrong");
  a_frac_field_write: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ctl_write |=> frac_r == $past(hwdata[16:13]) && shift_r == $past(hwdata[20:17]))
    else $error("scale fields did not take write");
  a_unipolar_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    pol_r && frac_r == 4'h8 && monitor_variable_value == '0 && $stable(pol_r)
      && $stable(frac_r) && $stable(monitor_variable_value) |=> monitor_output_one == '0)
    else $error("unipolar zero pu not at code zero");
  a_bipolar_mid: assert property (@(posedge hclk) disable iff (!hresetn)
    !pol_r && frac_r != 4'h0 && monitor_variable_value == '0 |=> monitor_output_one == DAC_W'(1) << (DAC_W - 1))
    else $error("bipolar zero pu not at mid scale");
  a_enum_zero_var: assert property (@(posedge hclk) disable iff (!hresetn)
    pol_r && frac_r == 4'h0 && monitor_variable_value == '0 |=> monitor_output_one == '0)
    else $error("enum zero not at code zero");
  a_enum_shift: assert property (@(posedge hclk) disable iff (!hresetn)
    pol_r && frac_r == 4'h0 && shift_r == 4'h0 && monitor_variable_value == VAR_W'(1)
      |=> monitor_output_one == DAC_W'(0))
    else $error("enum unit value with no shift misplaced");
endmodule : pgm_top
`default_nettype wire

/* tb/pgm_tb.sv */
// Self-checking bench: gain readback, control register and monitor DAC codes
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Stimulus and observed signals
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  // Size put on the bus by the master; word unless a scenario tests refusal
  logic [2:0]  xfer_size = 3'h2;
  logic [9:0]  cki = 10'h0, ckp = 10'h0, ski = 10'h0, skp = 10'h0;
  logic [15:0] mon_var = 16'h0;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, hready;
  wire  [11:0] mon_ptr, mon_code;
  logic [31:0] rd_s;
  logic        rdy_s;
  logic [31:0] rdv;
  int          bad_count = 0, total_checks = 0;
  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;
  // Values as they stand just before each rising edge, free of edge races
  always @(negedge hclk) begin
    rd_s  <= hrdata;
    rdy_s <= hready;
  end
  pgm_top u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cur_integral_gain_used(cki),
    .cur_proportional_gain_used(ckp), .spd_integral_gain_used(ski),
    .spd_proportional_gain_used(skp), .monitor_variable_value(mon_var),
    .monitor_one_variable_pointer(mon_ptr), .monitor_output_one(mon_code)
  );
  // ==========================================================
  // Reporting
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Scaling formulas leave rounding open, so a small tolerance is allowed
  task automatic check_near(string what, int exp, logic [11:0] got);
    total_checks++;
    if ((^got === 1'bx) || (int'(got) > exp + 3) || (int'(got) < exp - 3)) begin
      bad_count++;
      $display("mismatch %s expected %0d seen %h", what, exp, got);
    end
  endtask : check_near
  // ==========================================================
  // AHB-Lite master
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (rdy_s !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      $display("mismatch hready expected 1 seen timeout");
      print_verdict();
    end
  endtask : wait_ready
  task automatic ahb_xfer(logic [11:0] a, logic wr, logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= pgm_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= xfer_size;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    wait_ready();
    q = rd_s;
    check("response okay", 32'h0, {31'h0, hresp});
  endtask : ahb_xfer
  task automatic ahb_write(logic [11:0] a, logic [31:0] d);
    logic [31:0] q;
    ahb_xfer(a, 1'b1, d, q);
  endtask : ahb_write
  task automatic ahb_read(logic [11:0] a, output logic [31:0] q);
    ahb_xfer(a, 1'b0, 32'h0, q);
  endtask : ahb_read
  // ==========================================================
  // Expected DAC code: 1 pu is 0x8000, 12-bit full scale
  function automatic int exp_code(int v, int f, int sh, bit uni);
    real s, c;
    if (f == 0) s = ((v > 31) ? 31 : v) * (2.0 ** sh) / 32768.0;
    else s = v * f / 8.0 / 32768.0;
    c = uni ? s * 4095.0 : 2048.0 + s * 2048.0;
    if (c < 0.0) c = 0.0;
    if (c > 4095.0) c = 4095.0;
    return int'(c);
  endfunction : exp_code
  // Columns: variable, fraction field, power field, unipolar
  int dac_tab[13][4] = '{
    '{0, 8, 8, 1}, '{0, 8, 8, 0}, '{8192, 8, 8, 1}, '{8192, 4, 8, 1},
    '{8192, 15, 8, 1}, '{-16384, 8, 8, 1}, '{-16384, 8, 8, 0}, '{32767, 15, 8, 0},
    '{-32768, 8, 8, 0}, '{32767, 0, 10, 1}, '{4, 0, 11, 1}, '{32767, 0, 11, 1},
    '{8192, 1, 8, 0}};
  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    check("pointer after reset", 32'h0, {20'h0, mon_ptr});
    ahb_read(pgm_pkg::ADDR_MON1_CTRL, rdv);
    check("control reset", pgm_pkg::MON1_CTRL_RST, rdv);
    for (int i = 0; i < 2; i++) begin
      @(posedge hclk);
      cki <= i ? 10'h001 : 10'h3ff;
      ckp <= i ? 10'h2aa : 10'h155;
      ski <= i ? 10'h3ff : 10'h2aa;
      skp <= i ? 10'h155 : 10'h001;
      ahb_read(pgm_pkg::ADDR_CUR_GAIN, rdv);
      check("current gains", {6'h0, cki, 6'h0, ckp}, rdv);
      ahb_read(pgm_pkg::ADDR_SPD_GAIN, rdv);
      check("speed gains", {6'h0, ski, 6'h0, skp}, rdv);
    end
    ahb_write(pgm_pkg::ADDR_CUR_GAIN, 32'hffff_ffff);
    ahb_read(pgm_pkg::ADDR_CUR_GAIN, rdv);
    check("current gains after write", {6'h0, cki, 6'h0, ckp}, rdv);
    ahb_read(12'h100, rdv);
    check("unmapped read", 32'h0, rdv);
    ahb_write(pgm_pkg::ADDR_MON1_CTRL, 32'hffff_ffff);
    ahb_read(pgm_pkg::ADDR_MON1_CTRL, rdv);
    check("control all ones", 32'h001f_ffff, rdv);
    check("pointer all ones", 32'h0000_0fff, {20'h0, mon_ptr});
    ahb_write(pgm_pkg::ADDR_MON1_CTRL, 32'h0000_0a5c);
    ahb_read(pgm_pkg::ADDR_MON1_CTRL, rdv);
    check("control low pattern", 32'h0000_0a5c, rdv);
    // A byte-sized write must be ignored by the slave
    xfer_size = 3'h0;
    ahb_write(pgm_pkg::ADDR_MON1_CTRL, 32'h0000_0000);
    xfer_size = pgm_pkg::HSIZE_WORD;
    ahb_read(pgm_pkg::ADDR_MON1_CTRL, rdv);
    check("control after byte write", 32'h0000_0a5c, rdv);
    foreach (dac_tab[i]) begin
      @(posedge hclk);
      mon_var <= 16'(dac_tab[i][0]);
      ahb_write(pgm_pkg::ADDR_MON1_CTRL, {11'h0, 4'(dac_tab[i][2]), 4'(dac_tab[i][1]),
                                          1'(dac_tab[i][3]), 12'h0a5});
      repeat (3) @(posedge hclk);
      @(negedge hclk);
      check_near("dac code", exp_code(dac_tab[i][0], dac_tab[i][1], dac_tab[i][2],
                                      1'(dac_tab[i][3])), mon_code);
    end
    check("pointer field", 32'h0000_00a5, {20'h0, mon_ptr});
    // Second reset in mid-run must restore the control defaults
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    check("pointer after second reset", 32'h0, {20'h0, mon_ptr});
    ahb_read(pgm_pkg::ADDR_MON1_CTRL, rdv);
    check("control second reset", pgm_pkg::MON1_CTRL_RST, rdv);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
